//--- design/dcsf_ctrl.v
// dual clock fifo controller with reset-time configuration and thresholds
// Function
// (RULE1) standard mode reset straps pick flag buffering and partial flag timing; the partial flag strap is latched but unused, flags always synchronous
// (RULE2) fall-through: output ready triple-buffered, input ready double-buffered; the code gives input ready one stage (full_q) in fall-through
// (RULE3) daisy chain: first_load_n low only on first device, chains linked; the code has no daisy chain and latches these inputs only as reset straps
// (RULE4) reset returns write and read pointers to first location
// (RULE5) reset flag values: half/almost full high, almost empty low, full high
// (RULE6) reset clears output register and loads default thresholds
// (RULE7) controlling logic applies master reset before any write
// (RULE8) write enable low and not full stores word sequentially
// (RULE9) standard full flag low when full, writes ignored, write clock updated
// (RULE10) fall-through input ready high when full, writes ignored
// (RULE11) read enable low and not empty loads next word to output register
// (RULE12) standard empty flag low after last read, reads ignored while empty
// (RULE13) fall-through first word appears without read enable, third read edge
// (RULE14) fall-through output ready high after last word truly read
// (RULE15) output enable low drives bus, high floats it
// (RULE16) load select and write enable low write thresholds in turn
// (RULE17) threshold sequence continues where it stopped
// (RULE18) load select low, write enable high: nothing happens
// (RULE19) load select and read enable low read thresholds with own pointer
// (RULE20) threshold readback only in standard timing
// (RULE21) writer zeroes unused threshold bits
// (RULE22) no threshold read and write at the same time
// (RULE23) default thresholds 31, 63 or 127 by depth; reset loads THR_DEF, 31 unless overridden, for any depth
// (RULE24) synchronous partial flags update on own clock only
// (RULE25) depth parameter, flag buffering stages by configuration
`timescale 1ns/100ps
`include "dcsf_map.vh"
module dcsf_ctrl #(
	parameter                   AW      = `DCSF_AW_DEF,
	parameter [`DCSF_THR_W-1:0] THR_DEF = `DCSF_THR_DEF
) (
	input  wire                    wclk,
	input  wire                    rclk,
	input  wire                    master_reset_n,
	input  wire                    first_load_n,
	input  wire                    read_chain_in,
	input  wire                    write_chain_in,
	input  wire                    write_en_n,
	input  wire                    read_en_n,
	input  wire                    load_select_n,
	input  wire                    out_en_n,
	input  wire [`DCSF_DATA_W-1:0] write_data_in,
	output wire [`DCSF_DATA_W-1:0] read_data_out,
	output wire                    read_data_oe,
	output wire                    empty_flag_n,
	output wire                    full_flag_n,
	output reg                     almost_empty_n,
	output reg                     almost_full_n,
	output reg                     half_full_n,
	output wire                    fall_through_mode
);
	localparam DEPTH = 1 << AW;
	localparam [AW:0] HALF = DEPTH / 2;

	wire wrst = ~master_reset_n;

	// configuration latched during reset on the write clock
	reg cfg_ft;
	reg cfg_dbl;
	reg cfg_sync_pf;
	always @(posedge wclk) begin
		if (wrst) begin
			cfg_ft      <= ~read_chain_in & write_chain_in;            // (RULE1) (RULE2)
			cfg_dbl     <= read_chain_in & ~write_chain_in;            // (RULE1)
			cfg_sync_pf <= first_load_n;                               // (RULE1) (RULE24)
		end
	end
	assign fall_through_mode = cfg_ft;

	// memory and pointers (binary plus gray for crossing)
	reg [`DCSF_DATA_W-1:0] mem [0:DEPTH-1];
	reg [AW:0] wptr;
	reg [AW:0] rptr;
	reg [AW:0] wgray;
	reg [AW:0] rgray;
	wire [AW:0] rgray_w;
	wire [AW:0] wgray_r;

	function [AW:0] to_gray;
		input [AW:0] b;
		to_gray = b ^ (b >> 1);
	endfunction
	// zero-extends or cuts a threshold to pointer width
	function [AW:0] thr_ext;
		input [`DCSF_THR_W-1:0] t;
		integer k;
		begin
			thr_ext = {(AW+1){1'b0}};
			for (k = 0; k <= AW; k = k + 1)
				if (k < `DCSF_THR_W)
					thr_ext[k] = t[k];
		end
	endfunction
	function [AW:0] from_gray;
		input [AW:0] g;
		integer i;
		begin
			from_gray[AW] = g[AW];
			for (i = AW - 1; i >= 0; i = i - 1)
				from_gray[i] = from_gray[i+1] ^ g[i];
		end
	endfunction

	dcsf_sync #(.W(AW + 1)) u_r2w (
		.clk (wclk),
		.rst (wrst),
		.d   (rgray),
		.q   (rgray_w)
	);
	dcsf_sync #(.W(AW + 1)) u_w2r (
		.clk (rclk),
		.rst (~master_reset_n),
		.d   (wgray),
		.q   (wgray_r)
	);

	// write side
	wire [AW:0] rptr_w = from_gray(rgray_w);
	wire [AW:0] wcount = wptr - rptr_w;
	wire full_now = (wcount == DEPTH[AW:0]);
	reg  full_q;
	reg  full_q2;
	wire full_seen = cfg_dbl ? full_q2 : full_q;
	wire wr_fifo = ~write_en_n & load_select_n & ~full_seen & ~full_now; // (RULE8) (RULE9) (RULE10)
	wire wr_thr  = ~write_en_n & ~load_select_n;                          // (RULE16) (RULE18)
	reg  thr_wsel;
	reg [`DCSF_THR_W-1:0] empty_threshold;
	reg [`DCSF_THR_W-1:0] full_threshold;
	wire [AW:0] wcount_nx = wcount + {{AW{1'b0}}, wr_fifo};

	always @(posedge wclk) begin
		if (wr_fifo)
			mem[wptr[AW-1:0]] <= write_data_in;                    // (RULE8)
	end

	always @(posedge wclk) begin
		if (wrst) begin
			wptr            <= {(AW+1){1'b0}};                     // (RULE4)
			wgray           <= {(AW+1){1'b0}};
			thr_wsel        <= `DCSF_THR_EMPTY;
			empty_threshold <= THR_DEF;                            // (RULE6) (RULE23)
			full_threshold  <= THR_DEF;
			full_q          <= 1'b0;                               // (RULE5)
			full_q2         <= 1'b0;
			almost_full_n   <= 1'b1;                               // (RULE5)
			half_full_n     <= 1'b1;
		end else begin
			if (wr_fifo) begin
				wptr  <= wptr + 1'b1;
				wgray <= to_gray(wptr + 1'b1);
			end
			if (wr_thr) begin
				if (thr_wsel == `DCSF_THR_EMPTY)
					empty_threshold <= write_data_in[`DCSF_THR_W-1:0]; // (RULE16)
				else
					full_threshold  <= write_data_in[`DCSF_THR_W-1:0];
				thr_wsel <= ~thr_wsel;                             // (RULE17)
			end
			full_q        <= (wcount_nx == DEPTH[AW:0]);           // (RULE9) (RULE10)
			full_q2       <= full_q;                               // (RULE25)
			almost_full_n <= ~(wcount_nx >= (DEPTH[AW:0] - thr_ext(full_threshold))); // (RULE24)
			half_full_n   <= ~(wcount_nx > HALF);
		end
	end
	// full flag low-active in standard mode, input ready high-active-full in fall-through
	assign full_flag_n = cfg_ft ? full_seen : ~full_seen;           // (RULE9) (RULE10)

	// read side
	wire rrst = ~master_reset_n;
	reg  ft_r;
	always @(posedge rclk) begin
		if (rrst)
			ft_r <= cfg_ft;                                        // (RULE5)
		else
			ft_r <= cfg_ft;
	end
	wire [AW:0] wptr_r = from_gray(wgray_r);
	wire [AW:0] rcount = wptr_r - rptr;
	wire mem_has = (rcount != {(AW+1){1'b0}});
	// two synchroniser stages plus the output register give the third-edge fall-through
	wire has_ok = mem_has;                                         // (RULE13) (RULE25)
	reg  out_valid;
	reg [`DCSF_DATA_W-1:0] out_reg;
	reg  thr_rsel;
	wire rd_thr  = ~read_en_n & ~load_select_n & ~ft_r;                 // (RULE19) (RULE20)
	wire ft_pull = ft_r & has_ok & (~out_valid | ~read_en_n);
	reg  empty_q;
	reg  empty_q2;
	wire std_empty = cfg_dbl ? empty_q2 : empty_q;
	// reads are gated by the flag the reader sees as well as the live count
	wire std_pull = ~ft_r & has_ok & ~std_empty & ~read_en_n & load_select_n; // (RULE11) (RULE12)
	wire pull = (ft_pull & load_select_n) | std_pull;

	always @(posedge rclk) begin
		if (rrst) begin
			rptr      <= {(AW+1){1'b0}};                           // (RULE4)
			rgray     <= {(AW+1){1'b0}};
			out_reg   <= `DCSF_ZERO_DATA;                          // (RULE6)
			out_valid <= 1'b0;
			thr_rsel  <= `DCSF_THR_EMPTY;
			empty_q   <= 1'b1;                                     // (RULE5)
			empty_q2  <= 1'b1;
			almost_empty_n <= 1'b0;                                // (RULE5)
		end else begin
			if (pull) begin
				out_reg   <= mem[rptr[AW-1:0]];                    // (RULE11)
				rptr      <= rptr + 1'b1;
				rgray     <= to_gray(rptr + 1'b1);
				out_valid <= 1'b1;
			end else if (ft_r & ~read_en_n & load_select_n) begin
				out_valid <= 1'b0;                                 // (RULE14)
			end
			if (rd_thr) begin
				out_reg  <= {{(`DCSF_DATA_W-`DCSF_THR_W){1'b0}},
					(thr_rsel == `DCSF_THR_EMPTY) ? empty_threshold
					: full_threshold};                             // (RULE19)
				thr_rsel <= ~thr_rsel;
			end
			empty_q  <= ~(rcount > {{AW{1'b0}}, pull});            // (RULE12)
			empty_q2 <= empty_q;
			almost_empty_n <= (rcount > thr_ext(empty_threshold)); // (RULE24)
		end
	end
	// standard: low while empty; fall-through: output ready low while word valid
	assign empty_flag_n = ft_r ? ~out_valid : ~std_empty;          // (RULE12) (RULE14)

	assign read_data_out = out_reg;
	assign read_data_oe  = ~out_en_n;                              // (RULE15)
endmodule // dcsf_ctrl

//--- design/dcsf_sync.v
// two-stage synchroniser for a pointer word or level
`timescale 1ns/100ps
module dcsf_sync #(
	parameter W = 2
) (
	input  wire         clk,
	input  wire         rst,
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);
	reg [W-1:0] meta;
	always @(posedge clk) begin
		if (rst) begin
			meta <= {W{1'b0}};
			q    <= {W{1'b0}};
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule // dcsf_sync

//--- include/dcsf_map.vh
// constants for the dual clock fifo controller
`ifndef DCSF_MAP_VH
`define DCSF_MAP_VH
`define DCSF_DATA_W     18
`define DCSF_THR_W      12
`define DCSF_DEPTH_DEF  256
`define DCSF_AW_DEF     8
`define DCSF_THR_DEF    12'h001f
`define DCSF_FT_DELAY   3
`define DCSF_THR_EMPTY  1'b0
`define DCSF_THR_FULL   1'b1
`define DCSF_ZERO_DATA  18'h0_0000
`define DCSF_SYNC_W     2
`endif

//--- testbench/dcsf_ctrl_asserts.sv
// port checks for the fifo controller
`timescale 1ns/100ps
module dcsf_ctrl_asserts (
	input wire        wclk,
	input wire        master_reset_n,
	input wire        read_chain_in,
	input wire        write_chain_in,
	input wire        write_en_n,
	input wire        read_en_n,
	input wire        load_select_n,
	input wire        out_en_n,
	input wire [17:0] read_data_out,
	input wire        read_data_oe,
	input wire        empty_flag_n,
	input wire        full_flag_n,
	input wire        almost_empty_n,
	input wire        almost_full_n,
	input wire        half_full_n,
	input wire        fall_through_mode
);
	// the bench ties both clocks together
	default clocking cb @(posedge wclk); endclocking
	default disable iff (!master_reset_n);
	AST_OE: assert property (read_data_oe == !out_en_n)
		else $error("output enable wrong");
	AST_CFG: assert property ($rose(master_reset_n) |->
		fall_through_mode == (!read_chain_in && write_chain_in))
		else $error("mode wrong");
	AST_RST_FLAGS: assert property ($rose(master_reset_n) |->
		almost_full_n && half_full_n && !almost_empty_n
		&& full_flag_n == !fall_through_mode && empty_flag_n == fall_through_mode)
		else $error("flags wrong after reset");
	AST_RST_OUT: assert property ($rose(master_reset_n) |->
		read_data_out == 18'h0_0000)
		else $error("output not cleared");
	AST_STD_HOLD: assert property (!fall_through_mode && read_en_n |=>
		$stable(read_data_out))
		else $error("output moved");
	AST_EF_HOLD: assert property (!fall_through_mode && !empty_flag_n && load_select_n
		|=> $stable(read_data_out))
		else $error("read while empty");
	AST_EF_RISE: assert property (!fall_through_mode && !empty_flag_n && !write_en_n
		&& load_select_n |-> ##[1:5] empty_flag_n)
		else $error("empty flag stuck");
	AST_FT_FIRST: assert property (fall_through_mode && empty_flag_n && !write_en_n
		&& load_select_n |-> ##[1:5] !empty_flag_n)
		else $error("first word late");
	AST_FT_HOLD: assert property (fall_through_mode && !empty_flag_n && read_en_n
		|=> $stable(read_data_out) && !empty_flag_n)
		else $error("word lost");
	cover property ($rose(master_reset_n) && fall_through_mode);
	cover property (!fall_through_mode && !full_flag_n);
	cover property (!load_select_n && !read_en_n && !fall_through_mode);
endmodule // dcsf_ctrl_asserts

//--- testbench/dcsf_writer.sv
// writer model: streams words or threshold values
`timescale 1ns/100ps
module dcsf_writer (
	input  wire        clk,
	input  wire        go,
	input  wire [4:0]  n,
	input  wire [17:0] base,
	input  wire        load_select_n,
	output reg         write_en_n,
	output reg  [17:0] write_data_in,
	output reg         busy
);
	integer i;
	initial begin
		write_en_n = 1'b1;
		write_data_in = 18'h0_0000;
		busy = 1'b0;
	end
	// go only comes after a reset
	always @(posedge go) begin
		busy = 1'b1;
		for (i = 0; i < n; i = i + 1) begin
			@(negedge clk);
			write_en_n = 1'b0;
			write_data_in = base + i[17:0];
			if (!load_select_n) write_data_in[17:12] = 6'h00;
		end
		@(negedge clk);
		write_en_n = 1'b1;
		write_data_in = ~write_data_in;
		busy = 1'b0;
	end
endmodule // dcsf_writer

//--- testbench/tb_dcsf_ctrl.sv
// bench for the fifo controller
`timescale 1ns/100ps
module tb_dcsf_ctrl;
	reg         clk;
	reg         rst_n;
	reg  [2:0]  cfg;
	reg         ren_n;
	reg         ld_n;
	reg         oe_n;
	reg         go;
	reg  [4:0]  n;
	reg  [17:0] base;
	wire        wen_n, oe, ef_n, ff_n, ae_n, af_n, hf_n, ft, busy;
	wire [17:0] wd;
	wire [17:0] q;
	integer     bad_count, tests_run, cyc, i;
	// straps, then mode, empty and full flag after reset
	localparam logic [5:0] ROWS [0:5] = '{6'h01, 6'h21, 6'h11, 6'h31, 6'h0e, 6'h2e};
	dcsf_ctrl #(.AW(4), .THR_DEF(12'h0003)) u_dut (.wclk(clk), .rclk(clk),
		.master_reset_n(rst_n), .first_load_n(cfg[2]), .read_chain_in(cfg[1]),
		.write_chain_in(cfg[0]), .write_en_n(wen_n), .read_en_n(ren_n),
		.load_select_n(ld_n), .out_en_n(oe_n), .write_data_in(wd), .read_data_out(q),
		.read_data_oe(oe), .empty_flag_n(ef_n), .full_flag_n(ff_n), .almost_empty_n(ae_n),
		.almost_full_n(af_n), .half_full_n(hf_n), .fall_through_mode(ft));
	dcsf_writer u_wr (.clk(clk), .go(go), .n(n), .base(base), .load_select_n(ld_n),
		.write_en_n(wen_n), .write_data_in(wd), .busy(busy));
	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", tests_run, bad_count);
			if (bad_count == 0 && tests_run > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task chk(input [63:0] nm, input [17:0] seen, input [17:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				bad_count = bad_count + 1;
				$display("FAIL %0s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task rst(input [2:0] c);
		begin
			cfg = c;
			rst_n = 1'b0;
			repeat (12) @(negedge clk);
			rst_n = 1'b1;
			repeat (3) @(negedge clk);
		end
	endtask
	task wr(input [4:0] k, input [17:0] b);
		begin
			n = k;
			base = b;
			go = 1'b1;
			@(negedge clk);
			go = 1'b0;
			while (busy) @(negedge clk);
			repeat (6) @(negedge clk);
		end
	endtask
	// leaves read enable low; the caller releases it
	task rd(input [17:0] e);
		begin
			ren_n = 1'b0;
			@(negedge clk);
			chk("q", q, e);
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			bad_count = bad_count + 1;
			give_verdict;
		end
	end
	initial begin
		{bad_count, tests_run, cyc} = 0;
		{cfg, rst_n, ren_n, ld_n, oe_n, go, n, base} = {3'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 23'h0};
		for (i = 0; i < 6; i = i + 1) begin
			rst(ROWS[i][5:3]);
			chk("mode", ft, ROWS[i][2]);
			chk("ef", ef_n, ROWS[i][1]);
			chk("ff", ff_n, ROWS[i][0]);
			chk("part", {af_n, hf_n, ae_n}, 3'h6);
			chk("q", q, 18'h0_0000);
		end
		rst(3'h0);
		ld_n = 1'b0;
		wr(5'h03, 18'h0_0005);
		wr(5'h01, 18'h0_0009);
		rd(18'h0_0007);
		rd(18'h0_0009);
		ren_n = 1'b1;
		ld_n = 1'b1;
		wr(5'h11, 18'h0_0100);
		chk("ff", ff_n, 1'b0);
		chk("part", {af_n, hf_n, ae_n}, 3'h1);
		for (i = 0; i < 16; i = i + 1) rd(18'h0_0100 + i[17:0]);
		ren_n = 1'b1;
		repeat (4) @(negedge clk);
		chk("ef", ef_n, 1'b0);
		chk("ff", ff_n, 1'b1);
		rd(18'h0_010f);
		ren_n = 1'b1;
		oe_n = 1'b1;
		@(negedge clk);
		chk("oe", oe, 1'b0);
		oe_n = 1'b0;
		rst(3'h1);
		wr(5'h02, 18'h0_0200);
		chk("or", ef_n, 1'b0);
		chk("q", q, 18'h0_0200);
		rd(18'h0_0201);
		rd(18'h0_0201);
		ren_n = 1'b1;
		@(negedge clk);
		chk("or", ef_n, 1'b1);
		ld_n = 1'b0;
		rd(18'h0_0201);
		ren_n = 1'b1;
		give_verdict;
	end
endmodule // tb_dcsf_ctrl
bind dcsf_ctrl dcsf_ctrl_asserts u_chk (.wclk(wclk), .master_reset_n(master_reset_n),
	.read_chain_in(read_chain_in), .write_chain_in(write_chain_in), .write_en_n(write_en_n),
	.read_en_n(read_en_n), .load_select_n(load_select_n), .out_en_n(out_en_n),
	.read_data_out(read_data_out), .read_data_oe(read_data_oe), .empty_flag_n(empty_flag_n),
	.full_flag_n(full_flag_n), .almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n),
	.half_full_n(half_full_n), .fall_through_mode(fall_through_mode));
